// *** tsw_ctrl.sv ***
//==========================================================
// Purpose: controller end, sends one write frame per request
// Assumes: clk at 125 MHz, link clock made by divider
// Notes: data changes on the falling link clock edge
//==========================================================
`timescale 1ns/100ps
module tsw_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// request
	input wire logic wr_req,
	input wire logic [tsw_pkg::ROW_IDX_W-1:0] wr_row,
	input wire logic [tsw_pkg::ROW_W-1:0] wr_data,
	output logic wr_ready,
	// device reset request
	input wire logic dev_rst,
	// link
	tsw_if.ctrl link
);
	typedef enum logic [2:0] {
		TSW_IDLE, TSW_LO, TSW_HI, TSW_TAIL, TSW_GAP
	} tsw_state_t;

	localparam logic [tsw_pkg::TMR_W-1:0] HALF_TMR =
		tsw_pkg::TMR_W'(tsw_pkg::HALF_CYC - 1);
	localparam logic [tsw_pkg::TMR_W-1:0] LOW_TMR =
		tsw_pkg::TMR_W'(tsw_pkg::LOW_CYC - 1);
	localparam logic [tsw_pkg::TMR_W-1:0] TMR_ZERO = 4'h0;

	tsw_state_t st_ff;
	tsw_state_t nxt_st;
	logic [tsw_pkg::TMR_W-1:0] tmr_ff;
	logic [tsw_pkg::TMR_W-1:0] nxt_tmr;
	logic [tsw_pkg::CNT_W-1:0] bit_ff;
	logic [tsw_pkg::CNT_W-1:0] nxt_bit;
	tsw_pkg::tsw_frame_t sh_ff;
	tsw_pkg::tsw_frame_t nxt_sh;
	tsw_pkg::tsw_frame_t frame;
	logic sen_n_ff;
	logic nxt_sen_n;
	logic sclk_ff;
	logic nxt_sclk;
	logic rst_ff;
	logic tmr_done;

	//==========================================================
	// frame build and sequencing
	//==========================================================
	assign frame = {tsw_pkg::CHIP_ADDR, tsw_pkg::RW_WRITE,
		tsw_pkg::ADDR_HI_ZERO, wr_row, wr_data};
	assign tmr_done = (tmr_ff == TMR_ZERO);
	assign wr_ready = (st_ff == TSW_IDLE) && !rst_ff;

	always_comb begin
		nxt_st = st_ff;
		nxt_tmr = tmr_done ? tmr_ff : tmr_ff - 4'h1;
		nxt_bit = bit_ff;
		nxt_sh = sh_ff;
		nxt_sen_n = sen_n_ff;
		nxt_sclk = sclk_ff;
		case (st_ff)
			TSW_IDLE: begin
				if (wr_req && wr_ready) begin
					// enable low and bit 0 placed before first rise
					nxt_sen_n = 1'b0;
					nxt_sh = frame;
					nxt_bit = tsw_pkg::CNT_RST;
					nxt_tmr = HALF_TMR;
					nxt_st = TSW_LO;
				end
			end
			TSW_LO: begin
				if (tmr_done) begin
					nxt_sclk = 1'b1;
					nxt_tmr = HALF_TMR;
					nxt_st = TSW_HI;
				end
			end
			TSW_HI: begin
				if (tmr_done) begin
					nxt_sclk = 1'b0;
					nxt_sh = {1'b0, sh_ff[tsw_pkg::FRAME_BITS-1:1]};
					nxt_bit = bit_ff + 5'h01;
					if (bit_ff == tsw_pkg::LAST_BIT) begin
						nxt_tmr = LOW_TMR;
						nxt_st = TSW_TAIL;
					end else begin
						nxt_tmr = HALF_TMR;
						nxt_st = TSW_LO;
					end
				end
			end
			TSW_TAIL: begin
				if (tmr_done) begin
					// clock has been low long enough
					nxt_sen_n = 1'b1;
					nxt_tmr = HALF_TMR;
					nxt_st = TSW_GAP;
				end
			end
			TSW_GAP: begin
				if (tmr_done) begin
					nxt_st = TSW_IDLE;
				end
			end
			default: begin
				nxt_st = TSW_IDLE;
				nxt_sen_n = 1'b1;
				nxt_sclk = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= TSW_IDLE;
			tmr_ff <= TMR_ZERO;
			bit_ff <= tsw_pkg::CNT_RST;
		end else begin
			st_ff <= nxt_st;
			tmr_ff <= nxt_tmr;
			bit_ff <= nxt_bit;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sh_ff <= '0;
			sen_n_ff <= 1'b1;
			sclk_ff <= 1'b0;
			rst_ff <= 1'b0;
		end else begin
			sh_ff <= nxt_sh;
			sen_n_ff <= nxt_sen_n;
			sclk_ff <= nxt_sclk;
			rst_ff <= dev_rst;
		end
	end

	assign link.sen_n = sen_n_ff;
	assign link.sclk = sclk_ff;
	assign link.sdata = sh_ff[0];
	assign link.rst_pin = rst_ff;
endmodule

// *** tsw_dev.sv ***
//==========================================================
// Purpose: device end, captures frames and writes one row
// Assumes: controller keeps its timing on the link
// Notes: rows also mirrored into the clk domain
//==========================================================
// Behaviour
// - sixteen rows of eight bits, whole-row access
// - controller lowers enable, sets bit, then clocks
// - sample data each rising clock while enabled
// - write frame is exactly eighteen bits
// - data, row address, write flag, chip address
// - row address upper two bits always zero
// - write flag one requests row write
// - chip address 110 selects this device
// - row updates only at enable rise
// - clock low two ns before enable rises
// - reset pin clears array asynchronously
`timescale 1ns/100ps
module tsw_dev (
	// link
	tsw_if.dev link,
	// user clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// user side
	output tsw_pkg::tsw_rows_t cfg_rows,
	output logic row_wr,
	output logic frame_rej
);
	//==========================================================
	// link domain: shift and count
	//==========================================================
	tsw_pkg::tsw_frame_t shift_ff;
	tsw_pkg::tsw_frame_t nxt_shift;
	logic [tsw_pkg::CNT_W-1:0] cnt_ff;
	logic [tsw_pkg::CNT_W-1:0] nxt_cnt;
	logic cnt_full;

	assign cnt_full = (cnt_ff > tsw_pkg::FRAME_LEN);
	// bits arrive lsb first, so shift right
	assign nxt_shift = {link.sdata, shift_ff[tsw_pkg::FRAME_BITS-1:1]};
	// saturate one past the frame length to flag long frames
	assign nxt_cnt = cnt_full ? cnt_ff : cnt_ff + 5'h01;

	// high enable holds the capture logic idle between frames
	always_ff @(posedge link.sclk or posedge link.sen_n) begin
		if (link.sen_n) begin
			cnt_ff <= tsw_pkg::CNT_RST;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	always_ff @(posedge link.sclk or posedge link.sen_n) begin
		if (link.sen_n) begin
			shift_ff <= '0;
		end else begin
			shift_ff <= nxt_shift;
		end
	end

	//==========================================================
	// frame decode
	//==========================================================
	logic [tsw_pkg::ROW_W-1:0] f_data;
	logic [tsw_pkg::ADDR_W-1:0] f_addr;
	logic f_rw;
	logic [tsw_pkg::CHIP_W-1:0] f_chip;
	logic [tsw_pkg::ROW_IDX_W-1:0] f_row;
	logic len_ok;
	logic chip_ok;
	logic addr_ok;
	logic do_write;
	logic do_rej;

	assign f_data = shift_ff[tsw_pkg::DATA_LSB +: tsw_pkg::ROW_W];
	assign f_addr = shift_ff[tsw_pkg::ADDR_LSB +: tsw_pkg::ADDR_W];
	assign f_rw = shift_ff[tsw_pkg::RW_POS];
	assign f_chip = shift_ff[tsw_pkg::CHIP_LSB +: tsw_pkg::CHIP_W];
	assign f_row = f_addr[tsw_pkg::ROW_IDX_W-1:0];
	assign len_ok = (cnt_ff == tsw_pkg::FRAME_LEN);
	assign chip_ok = (f_chip == tsw_pkg::CHIP_ADDR);
	// upper address bits must be zero
	assign addr_ok = (f_addr[tsw_pkg::ADDR_W-1:tsw_pkg::ROW_IDX_W]
		== tsw_pkg::ADDR_HI_ZERO);
	assign do_write = len_ok && chip_ok && addr_ok
		&& (f_rw == tsw_pkg::RW_WRITE);
	assign do_rej = !do_write;

	//==========================================================
	// commit at enable rise
	//==========================================================
	// sclk is already low here, so shift and count are stable
	logic [tsw_pkg::ROW_W-1:0] array_ff [tsw_pkg::ROWS];
	logic wr_tgl_ff;
	logic rej_tgl_ff;

	always_ff @(posedge link.sen_n or posedge link.rst_pin) begin
		if (link.rst_pin) begin
			for (int i = 0; i < tsw_pkg::ROWS; i++) begin
				array_ff[i] <= tsw_pkg::ROW_RST;
			end
		end else if (do_write) begin
			array_ff[f_row] <= f_data;
		end
	end

	always_ff @(posedge link.sen_n or posedge link.rst_pin) begin
		if (link.rst_pin) begin
			wr_tgl_ff <= 1'b0;
		end else if (do_write) begin
			wr_tgl_ff <= !wr_tgl_ff;
		end
	end

	always_ff @(posedge link.sen_n or posedge link.rst_pin) begin
		if (link.rst_pin) begin
			rej_tgl_ff <= 1'b0;
		end else if (do_rej) begin
			rej_tgl_ff <= !rej_tgl_ff;
		end
	end

	//==========================================================
	// crossing into clk
	//==========================================================
	logic wr_s1_ff;
	logic wr_s2_ff;
	logic wr_s3_ff;
	logic rej_s1_ff;
	logic rej_s2_ff;
	logic rej_s3_ff;
	logic rst_s1_ff;
	logic rst_s2_ff;
	logic wr_evt;
	logic rej_evt;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_s1_ff <= 1'b0;
			wr_s2_ff <= 1'b0;
			wr_s3_ff <= 1'b0;
		end else begin
			wr_s1_ff <= wr_tgl_ff;
			wr_s2_ff <= wr_s1_ff;
			wr_s3_ff <= wr_s2_ff;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rej_s1_ff <= 1'b0;
			rej_s2_ff <= 1'b0;
			rej_s3_ff <= 1'b0;
		end else begin
			rej_s1_ff <= rej_tgl_ff;
			rej_s2_ff <= rej_s1_ff;
			rej_s3_ff <= rej_s2_ff;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= link.rst_pin;
			rst_s2_ff <= rst_s1_ff;
		end
	end

	assign wr_evt = wr_s2_ff ^ wr_s3_ff;
	assign rej_evt = rej_s2_ff ^ rej_s3_ff;

	//==========================================================
	// user mirror of the array
	//==========================================================
	// the array moves only at enable rise or reset pin rise, long before the
	// toggle reaches clk, so it is stable when copied
	tsw_pkg::tsw_rows_t mirror_ff;
	tsw_pkg::tsw_rows_t nxt_mirror;
	logic row_wr_ff;
	logic frame_rej_ff;

	always_comb begin
		nxt_mirror = mirror_ff;
		if (rst_s2_ff) begin
			nxt_mirror = '0;
		end else if (wr_evt) begin
			for (int i = 0; i < tsw_pkg::ROWS; i++) begin
				nxt_mirror[i] = array_ff[i];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mirror_ff <= '0;
		end else begin
			mirror_ff <= nxt_mirror;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			row_wr_ff <= 1'b0;
			frame_rej_ff <= 1'b0;
		end else begin
			row_wr_ff <= wr_evt && !rst_s2_ff;
			frame_rej_ff <= rej_evt && !rst_s2_ff;
		end
	end

	assign cfg_rows = mirror_ff;
	assign row_wr = row_wr_ff;
	assign frame_rej = frame_rej_ff;
endmodule

// *** tsw_if.sv ***
//==========================================================
// Purpose: three-wire serial link plus reset pin
// Assumes: controller drives every wire
// Notes: sclk is the device's link clock
//==========================================================
`timescale 1ns/100ps
interface tsw_if;
	logic sen_n;
	logic sclk;
	logic sdata;
	logic rst_pin;
	modport ctrl (
		output sen_n,
		output sclk,
		output sdata,
		output rst_pin
	);
	modport dev (
		input sen_n,
		input sclk,
		input sdata,
		input rst_pin
	);
endinterface

// *** tsw_link_checker.sv ***
//==========================================================
// Purpose: wire checks on the serial row write link
// Assumes: link driven from flops clocked by clk
// Notes: index of each link clock rise kept in cnt_ff
//==========================================================
`timescale 1ns/100ps
module tsw_link_checker (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// link
	input wire logic sen_n,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic rst_pin
);
	logic sclk_q_ff;
	logic [4:0] cnt_ff;
	wire logic rise = sclk & ~sclk_q_ff;
	wire logic [4:0] nxt_cnt = sen_n ? 5'h00 : cnt_ff + {4'h0, rise};
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_q_ff <= 1'b0;
			cnt_ff <= 5'h00;
		end else begin
			sclk_q_ff <= sclk;
			cnt_ff <= nxt_cnt;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_start; $fell(sen_n) |-> !sclk [*5] ##1 sclk; endproperty
	a_start: assert property (p_start)
		else $error("clock rose too early in frame");
	property p_idle; sen_n |-> !sclk; endproperty
	a_idle: assert property (p_idle)
		else $error("clock high outside frame");
	property p_half; $rose(sclk) |-> sclk [*5] ##1 !sclk; endproperty
	a_half: assert property (p_half)
		else $error("clock high time wrong");
	property p_hold; $rose(sclk) |=> $stable(sdata) [*4]; endproperty
	a_hold: assert property (p_hold)
		else $error("data moved while clock high");
	property p_count;
		$rose(sen_n) |-> cnt_ff == tsw_pkg::FRAME_LEN;
	endproperty
	a_count: assert property (p_count)
		else $error("frame pulse count wrong");
	property p_rw; rise && cnt_ff == 5'h0e |-> sdata; endproperty
	a_rw: assert property (p_rw)
		else $error("write flag not set");
	property p_chip;
		rise && cnt_ff >= 5'h0f && cnt_ff <= 5'h11 |->
			sdata == tsw_pkg::CHIP_ADDR[cnt_ff - 5'h0f];
	endproperty
	a_chip: assert property (p_chip)
		else $error("chip address bit wrong");
	property p_addr_hi;
		rise && (cnt_ff == 5'h0c || cnt_ff == 5'h0d) |-> !sdata;
	endproperty
	a_addr_hi: assert property (p_addr_hi)
		else $error("row address upper bit set");
endmodule

// *** tsw_pkg.sv ***
//==========================================================
// Purpose: shared constants of the serial row write port
// Assumes: 18-bit write frames, fields sent lsb first
// Notes: both ends and the link checker use these names
//==========================================================
package tsw_pkg;
	// array shape
	localparam int ROWS = 16;
	localparam int ROW_W = 8;
	localparam int ROW_IDX_W = 4;
	// frame layout
	localparam int FRAME_BITS = 18;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] FRAME_LEN = 5'h12;
	localparam logic [CNT_W-1:0] LAST_BIT = 5'h11;
	localparam int DATA_LSB = 0;
	localparam int ADDR_LSB = 8;
	localparam int ADDR_W = 6;
	localparam int RW_POS = 14;
	localparam int CHIP_LSB = 15;
	localparam int CHIP_W = 3;
	localparam logic [CHIP_W-1:0] CHIP_ADDR = 3'h6;
	localparam logic RW_WRITE = 1'b1;
	localparam logic [1:0] ADDR_HI_ZERO = 2'h0;
	// reset values
	localparam logic [ROW_W-1:0] ROW_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
	// timing at the controller clock
	localparam int CLK_PERIOD_PS = 8000;
	localparam int LINK_PERIOD_NS = 80;
	localparam int CLK_LOW_MIN_NS = 2;
	localparam int HALF_CYC =
		(LINK_PERIOD_NS * 1000 / 2) / CLK_PERIOD_PS;
	localparam int LOW_CYC_RAW =
		(CLK_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int LOW_CYC = (LOW_CYC_RAW < 1) ? 1 : LOW_CYC_RAW;
	localparam int TMR_W = 4;
	typedef logic [ROWS-1:0][ROW_W-1:0] tsw_rows_t;
	typedef logic [FRAME_BITS-1:0] tsw_frame_t;
endpackage

// *** tx_serial_row_write_port_bench.sv ***
//==========================================================
// Purpose: both ends joined, plus a faulty link to a 2nd device
// Assumes: checks sampled 1 ns after clk rise
// Notes: lnk2 is clocked by the bench at 80 ns
//==========================================================
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tx_serial_row_write_port_bench;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic wr_req = 1'b0;
	logic [3:0] wr_row = 4'h0;
	logic [7:0] wr_data = 8'h00;
	// the device array starts unknown until its reset pin pulses
	logic dev_rst = 1'b1;
	logic wr_ready, row_wr, frame_rej, wr2, rej2;
	tsw_pkg::tsw_rows_t cfg_rows, cfg2;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	tsw_if lnk ();
	tsw_if lnk2 ();
	always #4 clk = ~clk;
	tsw_ctrl tsw_ctrl_inst (.clk(clk), .arst_n(arst_n), .wr_req(wr_req),
		.wr_row(wr_row), .wr_data(wr_data), .wr_ready(wr_ready),
		.dev_rst(dev_rst), .link(lnk.ctrl));
	tsw_dev tsw_dev_inst (.link(lnk.dev), .clk(clk), .arst_n(arst_n),
		.cfg_rows(cfg_rows), .row_wr(row_wr), .frame_rej(frame_rej));
	tsw_dev tsw_dev_inst2 (.link(lnk2.dev), .clk(clk), .arst_n(arst_n),
		.cfg_rows(cfg2), .row_wr(wr2), .frame_rej(rej2));
	tsw_link_checker tsw_link_checker_inst (.clk(clk), .arst_n(arst_n),
		.sen_n(lnk.sen_n), .sclk(lnk.sclk), .sdata(lnk.sdata),
		.rst_pin(lnk.rst_pin));
	task automatic print_verdict;
		$display("checks %0d errors %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] r, input logic [7:0] d);
		logic [7:0] old;
		int i;
		old = cfg_rows[r];
		for (i = 0; i < 400 && wr_ready !== 1'b1; i++) tick;
		wr_req = 1'b1;
		wr_row = r;
		wr_data = d;
		tick;
		wr_req = 1'b0;
		for (i = 0; i < 400 && row_wr !== 1'b1; i++) begin
			if (i == 150) `CHK("held", old, cfg_rows[r])
			tick;
		end
		`CHK("row_wr", 1'b1, row_wr)
		`CHK("rej", 1'b0, frame_rej)
		`CHK("row", d, cfg_rows[r])
	endtask
	task automatic t_rows;
		wr(4'h0, 8'ha5);
		wr(4'hf, 8'h3c);
		wr(4'hf, 8'hc3);
		`CHK("rows", {8'hc3, 112'h0, 8'ha5}, cfg_rows)
	endtask
	task automatic t_rst;
		dev_rst = 1'b1;
		repeat (8) tick;
		`CHK("cleared", '0, cfg_rows)
		dev_rst = 1'b0;
		repeat (3) tick;
		wr(4'h4, 8'h81);
	endtask
	// lowers enable, sets bit 0, then clocks; data inverted after frame
	task automatic snd(input logic [17:0] f, input int n, input logic ok);
		int i;
		lnk2.sen_n = 1'b0;
		for (i = 0; i < n; i++) begin
			lnk2.sdata = f[i % 18];
			#40 lnk2.sclk = 1'b1;
			#40 lnk2.sclk = 1'b0;
		end
		#20 lnk2.sen_n = 1'b1;
		lnk2.sdata = ~lnk2.sdata;
		for (i = 0; i < 20 && wr2 !== 1'b1 && rej2 !== 1'b1; i++) tick;
		`CHK("wr2", ok, wr2)
		`CHK("rej2", ~ok, rej2)
	endtask
	task automatic t_faults;
		logic [17:0] fr [6];
		int nb [6];
		fr[0] = {3'h6, 1'b1, 6'h07, 8'ha5};
		fr[1] = {3'h5, 1'b1, 6'h07, 8'h5a};
		fr[2] = {3'h6, 1'b1, 6'h17, 8'h5a};
		fr[3] = {3'h6, 1'b0, 6'h07, 8'h5a};
		fr[4] = {3'h6, 1'b1, 6'h07, 8'h5a};
		fr[5] = fr[4];
		nb = '{18, 18, 18, 18, 17, 19};
		for (int k = 0; k < 6; k++) snd(fr[k], nb[k], k == 0);
		`CHK("rows2", {64'h0, 8'ha5, 56'h0}, cfg2)
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict;
		end
	end
	initial begin
		lnk2.sen_n = 1'b1;
		lnk2.sclk = 1'b0;
		lnk2.sdata = 1'b0;
		lnk2.rst_pin = 1'b1;
		repeat (10) @(posedge clk);
		#1 arst_n = 1'b1;
		// hold both reset pins so the arrays and toggles leave unknown
		repeat (6) tick;
		dev_rst = 1'b0;
		lnk2.rst_pin = 1'b0;
		repeat (4) tick;
		`CHK("rst", '0, cfg_rows)
		`CHK("rst2", '0, cfg2)
		t_rows;
		t_rst;
		// keep the bench link edges off the clk rising edge
		#2;
		t_faults;
		print_verdict;
	end
endmodule
